// File: rtl/sscr_consts.svh
/*
  constants of the status and system control register block: bit positions,
  reset values and write masks.
  assumes it is included by bare name from rtl/ files.
*/
`ifndef SSCR_CONSTS_SVH
`define SSCR_CONSTS_SVH

// status register bit positions
`define SSCR_ST_WDT_BIT    5
`define SSCR_ST_SLEEP_BIT  4
`define SSCR_ST_WRAP_BIT   3
`define SSCR_ST_ZERO_BIT   2
`define SSCR_ST_HALF_BIT   1
`define SSCR_ST_CARRY_BIT  0
// control register 0 bit positions
`define SSCR_C0_PGRP_BIT   7
`define SSCR_C0_FSRC_BIT   6
`define SSCR_C0_SPLIT_BIT  5
`define SSCR_C0_PWM1_BIT   4
`define SSCR_C0_PWM0_BIT   3
`define SSCR_C0_FDEN_HI    3
`define SSCR_C0_FDEN_LO    2
`define SSCR_C0_FDPIN_BIT  2
`define SSCR_C0_SLOW_CRYSTAL_LOW_POWER_BIT  1
`define SSCR_C0_CLK_BIT    0
// reset values
`define SSCR_SYSTEM_CONTROL_0_RESET   8'h00
`define SSCR_STATUS_RESET  8'h00
`define SSCR_PORT_DIR_RST  8'hFF
`define SSCR_PORT_DAT_RST  8'h00
// writable bits per variant, and of the status register
`define SSCR_MASK_SMALL    8'h07
`define SSCR_MASK_MID      8'h47
`define SSCR_MASK_DUAL     8'h7F
`define SSCR_MASK_PGRP     8'hCF
`define SSCR_STATUS_WMASK  8'h0F

`endif

// File: rtl/sscr_pkg.sv
/*
  types of the status and system control register block.
  assumes nothing beyond a systemverilog compiler.
*/
package sscr_pkg;
  // device variant of control register 0
  typedef enum logic [1:0] {
    SSCR_VAR_SMALL = 2'd0,
    SSCR_VAR_MID   = 2'd1,
    SSCR_VAR_DUAL  = 2'd2,
    SSCR_VAR_PGRP  = 2'd3
  } sscr_variant_t;

  // register selected by the core's special-function decode
  typedef enum logic [1:0] {
    SSCR_SEL_STATUS = 2'd0,
    SSCR_SEL_SYSTEM_CONTROL_0  = 2'd1,
    SSCR_SEL_PDATA  = 2'd2,
    SSCR_SEL_PDIR   = 2'd3
  } sscr_sel_t;

  // write kinds: whole byte, single-bit set, single-bit clear
  typedef enum logic [1:0] {
    SSCR_WR_BYTE = 2'd0,
    SSCR_WR_SET  = 2'd1,
    SSCR_WR_CLR  = 2'd2
  } sscr_wkind_t;

  // one access from the core
  typedef struct packed {
    logic        wr;
    sscr_sel_t   sel;
    sscr_wkind_t kind;
    logic [2:0]  bitn;
    logic [7:0]  wdata;
  } sscr_acc_t;

  // alu operands, result and flag-update controls for the current operation
  typedef struct packed {
    logic       upd_flags;
    logic       upd_carry_only;
    logic       is_sub;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] result;
    logic       carry_in;
    logic       rot_carry;
  } sscr_alu_t;

  // decoded system control outputs
  typedef struct packed {
    logic       fd_src_timer1;
    logic       pwm_split_71;
    logic       pwm1_on_pin;
    logic       pwm0_on_pin;
    logic       fd_true_en;
    logic       fd_inv_en;
    logic       xtal_low_power;
    logic       clk_slow;
    logic       rc_stop;
    logic       pin_group_c;
    logic       tp_from_sys;
  } sscr_ctrl_t;
endpackage

// File: rtl/sscr_port.sv
/*
  one 8-bit i/o port: data latch, direction latch, three-stage pin input
  synchroniser, pin drive with low-active output enable.
  assumes accesses are qualified by the main block on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sscr_consts.svh"
module sscr_port
  import sscr_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             dat_we_i,
  input  wire logic             dir_we_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] pin_o,
  output logic      [WIDTH-1:0] pin_oe_n_o,
  output logic      [WIDTH-1:0] dat_rd_o,
  output logic      [WIDTH-1:0] dir_rd_o
);
  logic [WIDTH-1:0] dat_q, dat_d;   // output latch
  logic [WIDTH-1:0] dir_q, dir_d;   // 1 input, 0 output
  logic [WIDTH-1:0] s1_q, s2_q, s3_q; // pin synchroniser stages
  logic [WIDTH-1:0] in_q, in_d;     // accepted pin level

  // next values of the latches and the filtered input
  always_comb begin
    dat_d = dat_we_i ? wdata_i : dat_q;
    dir_d = dir_we_i ? wdata_i : dir_q;
    in_d  = (s2_q == s3_q) ? s3_q : in_q;
  end

  // registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dat_q <= WIDTH'(`SSCR_PORT_DAT_RST);
      dir_q <= WIDTH'(`SSCR_PORT_DIR_RST);
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      in_q  <= '0;
    end else begin
      dat_q <= dat_d;
      dir_q <= dir_d;
      s1_q  <= pin_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      in_q  <= in_d;
    end
  end

  // pin drive: enable low while driving an output bit
  assign pin_o      = dat_q;
  assign pin_oe_n_o = dir_q;
  // read of the data register returns pin level for inputs, latch for outputs
  assign dat_rd_o   = (in_q & dir_q) | (dat_q & ~dir_q);
  assign dir_rd_o   = dir_q;
endmodule // sscr_port
`default_nettype wire

// File: rtl/sscr_regs.sv
/*
  status flags, one i/o port and system control register 0 of a small 8-bit
  microcontroller, as seen from the core's special-function access port.
  assumes the core presents one access and alu result per cycle on clk_i,
  and gives one-cycle pulses for clear-watchdog, halt and watchdog time-out.
  assumes the core drives carry_in high for a plain subtraction, so that the
  inverted-operand sum gives the no-borrow sense of half carry and carry.
  assumes variant and oscillator option are fixed when the part is built;
  nothing here lets software change them.
  the arithmetic flags come out of reset at zero; software must not count
  on that, as the flags only mean something after an operation or a write.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sscr_consts.svh"
module sscr_regs
  import sscr_pkg::*;
#(
  parameter sscr_variant_t VARIANT  = SSCR_VAR_DUAL,
  parameter int            PORT_W   = 8,
  parameter bit            COMBO_OSC = 1'b1
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire sscr_acc_t         acc_i,
  input  wire sscr_alu_t         alu_i,
  input  wire logic              clr_wdt_i,
  input  wire logic              halt_i,
  input  wire logic              wdt_timeout_i,
  input  wire logic [PORT_W-1:0] port_pin_i,
  input  wire logic              freq_div_timer0_i,
  input  wire logic              freq_div_timer1_i,
  input  wire logic              pwm0_i,
  input  wire logic              pwm1_i,
  output logic [7:0]             rdata_o,
  output logic [PORT_W-1:0]      port_pin_o,
  output logic [PORT_W-1:0]      port_pin_oe_n_o,
  output logic                   freq_div_output_o,
  output logic                   freq_div_output_inverted_o,
  output logic                   pwm0_pin_o,
  output logic                   pwm1_pin_o,
  output sscr_ctrl_t             ctrl_o
);
  // status flags
  // one register per flag; bits 7 and 6 have no storage
  logic wdt_expired_flag_q, wdt_expired_flag_d;
  logic sleep_entered_flag_q, sleep_entered_flag_d;
  logic signed_wrap_flag_q, signed_wrap_flag_d;
  logic zero_flag_q, zero_flag_d;
  logic half_carry_flag_q, half_carry_flag_d;
  logic carry_flag_q, carry_flag_d;
  // control register 0
  // held masked: only the variant's implemented bits are ever set
  logic [7:0] system_control_0_q, system_control_0_d;
  // divider outputs and read data
  // all three are registers, as data outputs of the block
  logic       fd_q, fd_d;
  logic       fdb_q, fdb_d;
  logic [7:0] rdata_q, rdata_d;
  // port access
  // strobes, write values with set/clear applied, register read-backs (pin level for input data bits)
  logic              pdat_we, pdir_we;
  logic [PORT_W-1:0] pdat_wv, pdir_wv;
  logic [PORT_W-1:0] pdat_rd, pdir_rd;
  logic [7:0]        st_now;

  // writable bits of control register 0 for the selected variant
  // bits outside the mask are never stored, so they read back as zero
  function automatic logic [7:0] ctrl_mask(input sscr_variant_t v);
    case (v)
      SSCR_VAR_SMALL: ctrl_mask = `SSCR_MASK_SMALL;
      SSCR_VAR_MID:   ctrl_mask = `SSCR_MASK_MID;
      SSCR_VAR_DUAL:  ctrl_mask = `SSCR_MASK_DUAL;
      default:        ctrl_mask = `SSCR_MASK_PGRP;
    endcase
  endfunction

  // new byte value for a byte, bit-set or bit-clear write
  // a set or clear rebuilds the whole byte from its present read value
  function automatic logic [7:0] apply_write(input logic [7:0] old,
                                             input sscr_acc_t a);
    logic [7:0] onehot;
    onehot = 8'h01 << a.bitn;
    case (a.kind)
      SSCR_WR_SET: apply_write = old | onehot;
      SSCR_WR_CLR: apply_write = old & ~onehot;
      default:     apply_write = a.wdata;
    endcase
  endfunction

  // status byte as read back; bits 7 and 6 read zero
  // this same byte feeds the single-bit writes to the status register
  always_comb begin
    st_now = 8'h00;
    st_now[`SSCR_ST_WDT_BIT]   = wdt_expired_flag_q;
    st_now[`SSCR_ST_SLEEP_BIT] = sleep_entered_flag_q;
    st_now[`SSCR_ST_WRAP_BIT]  = signed_wrap_flag_q;
    st_now[`SSCR_ST_ZERO_BIT]  = zero_flag_q;
    st_now[`SSCR_ST_HALF_BIT]  = half_carry_flag_q;
    st_now[`SSCR_ST_CARRY_BIT] = carry_flag_q;
  end

  // next values of the status flags
  // every flag holds unless an event, an alu update or a write touches it;
  // later assignments in this process take priority over earlier ones
  always_comb begin
    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] low7;
    logic [7:0] sw;
    logic       c7, c8;
    full = 9'h000;
    low  = 5'h00;
    low7 = 8'h00;
    sw   = 8'h00;
    c7   = 1'b0;
    c8   = 1'b0;
    wdt_expired_flag_d   = wdt_expired_flag_q;
    sleep_entered_flag_d = sleep_entered_flag_q;
    signed_wrap_flag_d   = signed_wrap_flag_q;
    zero_flag_d          = zero_flag_q;
    half_carry_flag_d    = half_carry_flag_q;
    carry_flag_d         = carry_flag_q;
    // system flags: time-out wins over a clear in the same cycle
    // halt wins over a clear-watchdog for the sleep flag
    if (clr_wdt_i || halt_i) begin
      wdt_expired_flag_d = 1'b0;
    end
    if (wdt_timeout_i) begin
      wdt_expired_flag_d = 1'b1;
    end
    if (clr_wdt_i) begin
      sleep_entered_flag_d = 1'b0;
    end
    if (halt_i) begin
      sleep_entered_flag_d = 1'b1;
    end
    // arithmetic flags; subtraction adds the inverted operand
    // wrap is the carry into bit 7 against the carry out of it
    if (alu_i.upd_flags) begin
      sw   = alu_i.is_sub ? ~alu_i.b : alu_i.b;
      full = {1'b0, alu_i.a} + {1'b0, sw} + {8'h00, alu_i.carry_in};
      low  = {1'b0, alu_i.a[3:0]} + {1'b0, sw[3:0]} + {4'h0, alu_i.carry_in};
      low7 = {1'b0, alu_i.a[6:0]} + {1'b0, sw[6:0]} + {7'h00, alu_i.carry_in};
      c7   = low7[7];
      c8   = full[8];
      signed_wrap_flag_d = c7 ^ c8;
      zero_flag_d        = (alu_i.result == 8'h00);
      half_carry_flag_d  = low[4];
      carry_flag_d       = c8;
    end else if (alu_i.upd_carry_only) begin
      carry_flag_d = alu_i.rot_carry;
    end
    // software writes reach only the four low flags
    // a write in the same cycle as an alu update wins over it
    if (acc_i.wr && acc_i.sel == SSCR_SEL_STATUS) begin
      sw = apply_write(st_now, acc_i) & `SSCR_STATUS_WMASK;
      signed_wrap_flag_d = sw[`SSCR_ST_WRAP_BIT];
      zero_flag_d        = sw[`SSCR_ST_ZERO_BIT];
      half_carry_flag_d  = sw[`SSCR_ST_HALF_BIT];
      carry_flag_d       = sw[`SSCR_ST_CARRY_BIT];
    end
  end

  // status registers
  // reset is synchronous, like every other register of the block
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wdt_expired_flag_q   <= 1'b0;
      sleep_entered_flag_q <= 1'b0;
      signed_wrap_flag_q   <= 1'b0;
      zero_flag_q          <= 1'b0;
      half_carry_flag_q    <= 1'b0;
      carry_flag_q         <= 1'b0;
    end else begin
      wdt_expired_flag_q   <= wdt_expired_flag_d;
      sleep_entered_flag_q <= sleep_entered_flag_d;
      signed_wrap_flag_q   <= signed_wrap_flag_d;
      zero_flag_q          <= zero_flag_d;
      half_carry_flag_q    <= half_carry_flag_d;
      carry_flag_q         <= carry_flag_d;
    end
  end

  // next value of control register 0
  // only a write changes it; masking and code clean-up happen before storage
  always_comb begin
    logic [7:0] nv;
    nv = 8'h00;
    system_control_0_d = system_control_0_q;
    if (acc_i.wr && acc_i.sel == SSCR_SEL_SYSTEM_CONTROL_0) begin
      nv = apply_write(system_control_0_q, acc_i) & ctrl_mask(VARIANT);
      // enable field code 01 is not held and reads zero
      if (VARIANT == SSCR_VAR_PGRP
          && nv[`SSCR_C0_FDEN_HI:`SSCR_C0_FDEN_LO] == 2'b01) begin
        nv[`SSCR_C0_FDEN_HI:`SSCR_C0_FDEN_LO] = 2'b00;
      end
      // without the combined oscillator the clock select stays zero
      if (!COMBO_OSC) begin
        nv[`SSCR_C0_CLK_BIT] = 1'b0;
      end
      system_control_0_d = nv;
    end
  end

  // control register
  // one byte, cleared by reset to the all-off state
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      system_control_0_q <= `SSCR_SYSTEM_CONTROL_0_RESET;
    end else begin
      system_control_0_q <= system_control_0_d;
    end
  end

  // decode of control register 0 into its functions
  // fields decoded in the variant case stay zero for variants that lack them; source select and clock bits are decoded for all
  always_comb begin
    logic [7:0] c;
    c = system_control_0_q;
    ctrl_o = '0;
    ctrl_o.fd_src_timer1  = c[`SSCR_C0_FSRC_BIT];
    ctrl_o.xtal_low_power = c[`SSCR_C0_SLOW_CRYSTAL_LOW_POWER_BIT];
    ctrl_o.clk_slow       = c[`SSCR_C0_CLK_BIT];
    ctrl_o.rc_stop        = c[`SSCR_C0_CLK_BIT];
    case (VARIANT)
      SSCR_VAR_PGRP: begin
        ctrl_o.pin_group_c = c[`SSCR_C0_PGRP_BIT];
        ctrl_o.fd_true_en  = c[`SSCR_C0_FDEN_HI];
        ctrl_o.fd_inv_en   = c[`SSCR_C0_FDEN_HI] & c[`SSCR_C0_FDEN_LO];
      end
      SSCR_VAR_DUAL: begin
        ctrl_o.pwm_split_71 = c[`SSCR_C0_SPLIT_BIT];
        ctrl_o.pwm1_on_pin  = c[`SSCR_C0_PWM1_BIT];
        ctrl_o.pwm0_on_pin  = c[`SSCR_C0_PWM0_BIT];
        ctrl_o.fd_true_en   = c[`SSCR_C0_FDPIN_BIT];
      end
      default: begin
        ctrl_o.fd_true_en = c[`SSCR_C0_FDPIN_BIT];
      end
    endcase
    // any pwm on a pin takes the timer clock from the system clock
    ctrl_o.tp_from_sys = ctrl_o.pwm0_on_pin | ctrl_o.pwm1_on_pin;
  end

  // divider output selection and enables
  // true and inverted outputs come from one source sample, so they
  // never show the same level when both are enabled
  always_comb begin
    logic src;
    src   = ctrl_o.fd_src_timer1 ? freq_div_timer1_i : freq_div_timer0_i;
    fd_d  = ctrl_o.fd_true_en & src;
    fdb_d = ctrl_o.fd_inv_en & ~src;
  end

  // divider output flops
  // registered so the pins see no glitch when the source select changes
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fd_q  <= 1'b0;
      fdb_q <= 1'b0;
    end else begin
      fd_q  <= fd_d;
      fdb_q <= fdb_d;
    end
  end

  assign freq_div_output_o          = fd_q;
  assign freq_div_output_inverted_o = fdb_q;
  // pwm channels reach their pins only when enabled
  // left combinational so the pulse edges keep the channel's own timing
  assign pwm0_pin_o = ctrl_o.pwm0_on_pin & pwm0_i;
  assign pwm1_pin_o = ctrl_o.pwm1_on_pin & pwm1_i;

  // port write strobes with bit set and clear applied
  // a set or clear reads the pins for input bits and writes that level back
  // into the latch; a later switch to output then drives the sampled level
  always_comb begin
    pdat_we = acc_i.wr && acc_i.sel == SSCR_SEL_PDATA;
    pdir_we = acc_i.wr && acc_i.sel == SSCR_SEL_PDIR;
    pdat_wv = PORT_W'(apply_write(8'(pdat_rd & port_pin_oe_n_o | port_pin_o & ~port_pin_oe_n_o), acc_i));
    pdir_wv = PORT_W'(apply_write(8'(pdir_rd), acc_i));
  end

  // the port
  // one data word feeds both latches; only one write strobe rises at a time
  sscr_port #(
    .WIDTH (PORT_W)
  ) u_port (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .dat_we_i   (pdat_we),
    .dir_we_i   (pdir_we),
    .wdata_i    (pdat_we ? pdat_wv : pdir_wv),
    .pin_i      (port_pin_i),
    .pin_o      (port_pin_o),
    .pin_oe_n_o (port_pin_oe_n_o),
    .dat_rd_o   (pdat_rd),
    .dir_rd_o   (pdir_rd)
  );

  // registered read data of the selected register
  // the select of one cycle gives its data on the next; reads need no strobe
  always_comb begin
    case (acc_i.sel)
      SSCR_SEL_STATUS: rdata_d = st_now;
      SSCR_SEL_SYSTEM_CONTROL_0:  rdata_d = system_control_0_q;
      SSCR_SEL_PDATA:  rdata_d = 8'(pdat_rd);
      SSCR_SEL_PDIR:   rdata_d = 8'(pdir_rd);
      default:         rdata_d = 8'h00;
    endcase
  end

  // read data register
  // cleared by reset so the first read after release is defined
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;
endmodule // sscr_regs
`default_nettype wire

// File: sim/sscr_regs_asserts.sv
/*
  checker for sscr_regs: port, control 0 and output gating relations.
  assumes it is bound to sscr_regs and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module sscr_regs_asserts
  import sscr_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input wire logic              clk_i,
  input wire logic              reset_i,
  input wire sscr_acc_t         acc_i,
  input wire sscr_alu_t         alu_i,
  input wire logic              clr_wdt_i,
  input wire logic              halt_i,
  input wire logic              wdt_timeout_i,
  input wire logic [PORT_W-1:0] port_pin_i,
  input wire logic              freq_div_timer0_i,
  input wire logic              freq_div_timer1_i,
  input wire logic              pwm0_i,
  input wire logic              pwm1_i,
  input wire logic [7:0]        rdata_o,
  input wire logic [PORT_W-1:0] port_pin_o,
  input wire logic [PORT_W-1:0] port_pin_oe_n_o,
  input wire logic              freq_div_output_o,
  input wire logic              freq_div_output_inverted_o,
  input wire logic              pwm0_pin_o,
  input wire logic              pwm1_pin_o,
  input wire sscr_ctrl_t        ctrl_o
);
  // one clock domain, one reset
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // byte writes to the direction, data and control registers, and a single-bit set of the direction register
  sequence s_dir_wr;
    acc_i.wr && acc_i.sel == SSCR_SEL_PDIR && acc_i.kind == SSCR_WR_BYTE;
  endsequence
  sequence s_dat_wr;
    acc_i.wr && acc_i.sel == SSCR_SEL_PDATA && acc_i.kind == SSCR_WR_BYTE;
  endsequence
  sequence s_dir_set;
    acc_i.wr && acc_i.sel == SSCR_SEL_PDIR && acc_i.kind == SSCR_WR_SET;
  endsequence
  sequence s_ctl_wr;
    acc_i.wr && acc_i.sel == SSCR_SEL_SYSTEM_CONTROL_0 && acc_i.kind == SSCR_WR_BYTE;
  endsequence
  // divider enabled and fed from timer 1
  sequence s_fd_t1;
    ctrl_o.fd_true_en && ctrl_o.fd_src_timer1;
  endsequence

  AST_DIR_BYTE: assert property (s_dir_wr |=> port_pin_oe_n_o == $past(acc_i.wdata))
    else $error("direction write not seen on output enables");
  AST_DAT_BYTE: assert property (s_dat_wr |=> port_pin_o == $past(acc_i.wdata))
    else $error("data write not seen on pin drive");
  AST_DIR_SET: assert property (s_dir_set |=> port_pin_oe_n_o[$past(acc_i.bitn)])
    else $error("direction bit set not applied");
  AST_XTAL_LP: assert property (s_ctl_wr |=> ctrl_o.xtal_low_power == $past(acc_i.wdata[1]))
    else $error("crystal low power bit not stored");
  AST_PWM0_GATE: assert property (pwm0_pin_o == (pwm0_i && ctrl_o.pwm0_on_pin))
    else $error("pwm0 pin gating wrong");
  AST_PWM1_GATE: assert property (pwm1_pin_o == (pwm1_i && ctrl_o.pwm1_on_pin))
    else $error("pwm1 pin gating wrong");
  AST_RC_STOP: assert property (ctrl_o.clk_slow |-> ctrl_o.rc_stop)
    else $error("rc oscillator not stopped on slow clock");
  AST_TP_SYS: assert property ((ctrl_o.pwm0_on_pin || ctrl_o.pwm1_on_pin) |-> ctrl_o.tp_from_sys)
    else $error("timer clock not from system clock");
  AST_FD_OFF: assert property (!$past(ctrl_o.fd_true_en) |-> !freq_div_output_o)
    else $error("divider output active while disabled");
  AST_FD_SRC: assert property (s_fd_t1 |=> freq_div_output_o == $past(freq_div_timer1_i))
    else $error("divider output not from timer 1");
  AST_RST_VAL: assert property ($fell(reset_i) |-> ctrl_o == '0 && port_pin_oe_n_o == '1)
    else $error("control or direction not at reset value");
endmodule // sscr_regs_asserts
`default_nettype wire

// File: sim/sscr_regs_test.sv
/*
  self-checking testbench for sscr_regs: flags, port and control 0.
  assumes the dual-bank variant with combined oscillators, plus a pin-group copy without them, 25 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
bind sscr_regs sscr_regs_asserts #(.PORT_W(PORT_W)) sscr_regs_asserts_i (
  .clk_i(clk_i), .reset_i(reset_i), .acc_i(acc_i), .alu_i(alu_i), .clr_wdt_i(clr_wdt_i),
  .halt_i(halt_i), .wdt_timeout_i(wdt_timeout_i), .port_pin_i(port_pin_i),
  .freq_div_timer0_i(freq_div_timer0_i), .freq_div_timer1_i(freq_div_timer1_i),
  .pwm0_i(pwm0_i), .pwm1_i(pwm1_i), .rdata_o(rdata_o), .port_pin_o(port_pin_o),
  .port_pin_oe_n_o(port_pin_oe_n_o), .freq_div_output_o(freq_div_output_o),
  .freq_div_output_inverted_o(freq_div_output_inverted_o), .pwm0_pin_o(pwm0_pin_o),
  .pwm1_pin_o(pwm1_pin_o), .ctrl_o(ctrl_o));
module sscr_regs_test
  import sscr_pkg::*;
();
  // one alu case and the four low flags it should leave
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic       cin;
    logic       sub;
    logic [3:0] flg;
  } sscr_row_t;
  logic       clk_i, reset_i, clr, hlt, tmo, t0, t1, p0, p1, fdo, fdi, pw0, pw1, fdo2, fdi2;
  logic [7:0] pins, rdata, pdrv, oe_n, rdata2;
  sscr_acc_t  acc;   // core access
  sscr_alu_t  alu;   // alu flag inputs
  sscr_ctrl_t ctrl;  // decoded control
  sscr_ctrl_t ctrl2; // decoded control, pin-group copy
  int         err_total, tests_run;
  // add/sub cases: wrap, zero, half carry, carry
  sscr_row_t  rows[6] = '{'{8'h7F, 8'h01, 1'b0, 1'b0, 4'hA}, '{8'hFF, 8'h01, 1'b0, 1'b0, 4'h7},
    '{8'h05, 8'h03, 1'b1, 1'b1, 4'h3}, '{8'h03, 8'h05, 1'b1, 1'b1, 4'h0},
    '{8'h80, 8'h01, 1'b1, 1'b1, 4'h9}, '{8'h00, 8'h00, 1'b0, 1'b0, 4'h4}};

  sscr_regs #(.VARIANT(SSCR_VAR_DUAL), .PORT_W(8), .COMBO_OSC(1'b1)) sscr_regs_i (
    .clk_i(clk_i), .reset_i(reset_i), .acc_i(acc), .alu_i(alu), .clr_wdt_i(clr),
    .halt_i(hlt), .wdt_timeout_i(tmo), .port_pin_i(pins), .freq_div_timer0_i(t0),
    .freq_div_timer1_i(t1), .pwm0_i(p0), .pwm1_i(p1), .rdata_o(rdata), .port_pin_o(pdrv),
    .port_pin_oe_n_o(oe_n), .freq_div_output_o(fdo), .freq_div_output_inverted_o(fdi),
    .pwm0_pin_o(pw0), .pwm1_pin_o(pw1), .ctrl_o(ctrl));
  // second copy: pin-group variant without the combined oscillator option
  sscr_regs #(.VARIANT(SSCR_VAR_PGRP), .PORT_W(8), .COMBO_OSC(1'b0)) sscr_regs_pgrp_i (
    .clk_i(clk_i), .reset_i(reset_i), .acc_i(acc), .alu_i(alu), .clr_wdt_i(clr),
    .halt_i(hlt), .wdt_timeout_i(tmo), .port_pin_i(pins), .freq_div_timer0_i(t0),
    .freq_div_timer1_i(t1), .pwm0_i(p0), .pwm1_i(p1), .rdata_o(rdata2), .port_pin_o(),
    .port_pin_oe_n_o(), .freq_div_output_o(fdo2), .freq_div_output_inverted_o(fdi2),
    .pwm0_pin_o(), .pwm1_pin_o(), .ctrl_o(ctrl2));

  // 40 ns clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // verdict and end of run
  task automatic give_verdict;
    if (err_total == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // byte compare, also used for single bits
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %0t byte %h want %h", $time, got, exp);
    end
  endtask

  // decoded control compare
  task automatic chk_ctrl(input sscr_ctrl_t got, input sscr_ctrl_t exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %0t control %h want %h", $time, got, exp);
    end
  endtask

  // one write access, effect lands at the second edge
  task automatic wr(input sscr_sel_t s, input sscr_wkind_t k, input logic [2:0] n,
                    input logic [7:0] d);
    @(posedge clk_i);
    acc <= '{wr: 1'b1, sel: s, kind: k, bitn: n, wdata: d};
    @(posedge clk_i);
    acc.wr <= 1'b0;
  endtask

  // read: select, then registered data one edge later
  task automatic rd(input sscr_sel_t s, input logic [7:0] e);
    @(posedge clk_i);
    acc <= '{wr: 1'b0, sel: s, kind: SSCR_WR_BYTE, bitn: 3'h0, wdata: 8'h00};
    @(posedge clk_i);
    #1 chk_byte(rdata, e);
  endtask

  // one-cycle clear-watchdog, halt and time-out pulses
  task automatic ev(input logic c, input logic h, input logic t);
    @(posedge clk_i);
    {clr, hlt, tmo} <= {c, h, t};
    @(posedge clk_i);
    {clr, hlt, tmo} <= 3'b000;
  endtask

  // one flag-updating alu operation; sub passes raw b
  task automatic op(input sscr_row_t r);
    logic [7:0] bb;
    bb = r.sub ? ~r.b : r.b;
    @(posedge clk_i);
    alu <= '{upd_flags: 1'b1, upd_carry_only: 1'b0, is_sub: r.sub, a: r.a, b: r.b,
             result: r.a + bb + {7'h0, r.cin}, carry_in: r.cin, rot_carry: 1'b0};
    @(posedge clk_i);
    alu <= '0;
  endtask

  // hang guard, far above the expected run of about 120 cycles
  initial begin
    #(40 * 3000);
    err_total++;
    give_verdict();
  end

  initial begin
    acc = '0;
    alu = '0;
    {clr, hlt, tmo, t0} = 4'h0;
    {t1, p0, p1} = 3'b111;
    pins = 8'hA5;
    reset_i = 1'b1;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    #1 chk_ctrl(ctrl, '0);
    chk_byte(oe_n, 8'hFF);
    chk_byte({6'h0, pw1, pw0}, 8'h00);
    rd(SSCR_SEL_STATUS, 8'h00);
    // table of alu cases
    foreach (rows[i]) begin
      op(rows[i]);
      rd(SSCR_SEL_STATUS, {4'h0, rows[i].flg});
    end
    // rotate touches carry only
    @(posedge clk_i);
    alu <= '{upd_carry_only: 1'b1, rot_carry: 1'b1, default: '0};
    @(posedge clk_i);
    alu <= '0;
    rd(SSCR_SEL_STATUS, 8'h05);
    wr(SSCR_SEL_STATUS, SSCR_WR_BYTE, 3'h0, 8'hFF);
    rd(SSCR_SEL_STATUS, 8'h0F);
    ev(1'b0, 1'b1, 1'b0);
    rd(SSCR_SEL_STATUS, 8'h1F);
    ev(1'b0, 1'b0, 1'b1);
    rd(SSCR_SEL_STATUS, 8'h3F);
    ev(1'b0, 1'b1, 1'b0);
    rd(SSCR_SEL_STATUS, 8'h1F);
    ev(1'b1, 1'b0, 1'b1);
    rd(SSCR_SEL_STATUS, 8'h2F);
    ev(1'b1, 1'b0, 1'b0);
    rd(SSCR_SEL_STATUS, 8'h0F);
    // software write beats a same-cycle flag update
    fork
      wr(SSCR_SEL_STATUS, SSCR_WR_BYTE, 3'h0, 8'h00);
      op(rows[1]);
    join
    ev(1'b1, 1'b1, 1'b0);
    rd(SSCR_SEL_STATUS, 8'h10);
    // control 0: all bits, then divider only
    wr(SSCR_SEL_SYSTEM_CONTROL_0, SSCR_WR_BYTE, 3'h0, 8'hFF);
    #1 chk_ctrl(ctrl, 11'h7DD);
    chk_ctrl(ctrl2, 11'h472);
    chk_byte({6'h0, pw1, pw0}, 8'h03);
    @(posedge clk_i) p0 <= 1'b0;
    #1 chk_byte({6'h0, pw1, pw0}, 8'h02);
    repeat (2) @(posedge clk_i);
    #1 chk_byte({6'h0, fdi, fdo}, 8'h01);
    chk_byte({6'h0, fdi2, fdo2}, 8'h01);
    rd(SSCR_SEL_SYSTEM_CONTROL_0, 8'h7F);
    chk_byte(rdata2, 8'hCE);
    wr(SSCR_SEL_SYSTEM_CONTROL_0, SSCR_WR_BYTE, 3'h0, 8'h04);
    #1 chk_ctrl(ctrl, 11'h040);
    chk_ctrl(ctrl2, '0);
    repeat (2) @(posedge clk_i);
    #1 chk_byte({5'h0, pw1, pw0, fdo}, 8'h00);
    @(posedge clk_i) t0 <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk_byte({7'h0, fdo}, 8'h01);
    wr(SSCR_SEL_SYSTEM_CONTROL_0, SSCR_WR_BYTE, 3'h0, 8'h0C);
    t0 <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 chk_byte({6'h0, fdi2, fdo2}, 8'h02);
    // port direction and data, single-bit writes
    wr(SSCR_SEL_PDIR, SSCR_WR_BYTE, 3'h0, 8'h0F);
    #1 chk_byte(oe_n, 8'h0F);
    wr(SSCR_SEL_PDIR, SSCR_WR_SET, 3'h7, 8'h00);
    #1 chk_byte(oe_n, 8'h8F);
    wr(SSCR_SEL_PDIR, SSCR_WR_CLR, 3'h0, 8'h00);
    #1 chk_byte(oe_n, 8'h8E);
    rd(SSCR_SEL_PDIR, 8'h8E);
    wr(SSCR_SEL_PDATA, SSCR_WR_BYTE, 3'h0, 8'hA5);
    #1 chk_byte(pdrv, 8'hA5);
    rd(SSCR_SEL_PDATA, 8'hA5);
    wr(SSCR_SEL_PDATA, SSCR_WR_CLR, 3'h0, 8'h00);
    #1 chk_byte(pdrv, 8'hA4);
    @(posedge clk_i) pins <= 8'h5A;
    wr(SSCR_SEL_PDIR, SSCR_WR_BYTE, 3'h0, 8'hFF);
    repeat (6) @(posedge clk_i);
    rd(SSCR_SEL_PDATA, 8'h5A);
    // reset in mid-run
    @(posedge clk_i) reset_i <= 1'b1;
    @(posedge clk_i) reset_i <= 1'b0;
    #1 chk_ctrl(ctrl, '0);
    chk_ctrl(ctrl2, '0);
    chk_byte(oe_n, 8'hFF);
    rd(SSCR_SEL_STATUS, 8'h00);
    give_verdict();
  end
endmodule // sscr_regs_test
`default_nettype wire
